// File: logic/bse_regs.svh
`ifndef BSE_REGS_SVH
`define BSE_REGS_SVH

// Status flag positions
`define BSE_FLAG_C 3'h0
`define BSE_FLAG_Z 3'h1
`define BSE_FLAG_N 3'h2
`define BSE_FLAG_V 3'h3
`define BSE_FLAG_S 3'h4
`define BSE_FLAG_H 3'h5
`define BSE_FLAG_T 3'h6
`define BSE_FLAG_I 3'h7

// Reset values
`define BSE_FLAGS_RST 8'h00
`define BSE_DATA_RST 8'h00
`define BSE_IOADDR_RST 6'h00

// Cycle counts per operation
`define BSE_IO_SET_CYCLES 2
`define BSE_ONE_CYCLE 1

`endif

// File: logic/bse_pkg.sv
`default_nettype none

package bse_pkg;

    typedef enum logic [3:0] {
        BSE_IO_BIT_SET = 4'h0,
        BSE_IO_BIT_CLEAR = 4'h1,
        BSE_LOGICAL_LEFT_SHIFT = 4'h2,
        BSE_LOGICAL_RIGHT_SHIFT = 4'h3,
        BSE_ROTATE_LEFT_CARRY = 4'h4,
        BSE_ROTATE_RIGHT_CARRY = 4'h5,
        BSE_ARITH_RIGHT_SHIFT = 4'h6,
        BSE_SWAP = 4'h7,
        BSE_FLAG_SET = 4'h8,
        BSE_FLAG_CLEAR = 4'h9,
        BSE_BIT_TO_T = 4'hA,
        BSE_T_TO_BIT = 4'hB,
        BSE_CARRY_SET = 4'hC,
        BSE_CARRY_CLEAR = 4'hD,
        BSE_NEG_SET = 4'hE,
        BSE_NEG_CLEAR = 4'hF
    } bse_op_t;

    typedef enum logic [1:0] {
        BSE_ST_IDLE = 2'b01,
        BSE_ST_IO_HOLD = 2'b10
    } bse_state_t;

    typedef struct packed {
        logic [7:0] dst_value;
        logic [7:0] source_register;
        logic [7:0] io_value;
        logic [5:0] io_addr;
        logic [2:0] bit_sel;
    } bse_operand_t;

    typedef struct packed {
        logic wr_en;
        logic [7:0] value;
    } bse_reg_wr_t;

    typedef struct packed {
        logic wr_en;
        logic [5:0] addr;
        logic [7:0] data;
    } bse_io_wr_t;

endpackage

`default_nettype wire

// File: logic/bse_unit.sv
// Operation
// - I/O bit set forces chosen bit high, flags untouched, two cycles.
// - I/O bit clear forces chosen bit low, flags untouched.
// - Logical left shift, zero into bit 0, updates Z C N V, one cycle.
// - Logical right shift, zero into bit 7, updates Z C N V.
// - Rotate left: old carry into bit 0, old bit 7 to carry.
// - Rotate right: old carry into bit 7, old bit 0 to carry.
// - Arithmetic right shift keeps sign bit, updates Z C N V.
// - Nibble swap exchanges halves, no flag change, one cycle.
// - Flag set/clear writes one/zero to the selected status bit only.
// - Bit store copies selected source bit into transfer flag, one cycle.
// - Bit load copies transfer flag into selected destination bit, flags kept.
// - Carry set/clear drives carry one/zero only, one cycle.
// - Negative set/clear drives negative one/zero only.
`include "bse_regs.svh"

`default_nettype none

module bse_unit (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire bse_pkg::bse_op_t op,
    input wire bse_pkg::bse_operand_t opnd,
    output var logic ready_reg,
    output var bse_pkg::bse_reg_wr_t dst_wr_reg,
    output var bse_pkg::bse_io_wr_t io_wr_reg,
    output var logic [7:0] status_flags_register
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    bse_pkg::bse_state_t state_reg;
    bse_pkg::bse_state_t state_next;
    logic ready_next;
    bse_pkg::bse_reg_wr_t dst_wr_next;
    bse_pkg::bse_io_wr_t io_wr_next;
    bse_pkg::bse_io_wr_t io_hold_reg;
    bse_pkg::bse_io_wr_t io_hold_next;
    logic [7:0] flags_next;
    logic [7:0] shift_res;
    logic shift_c;
    logic shift_n;
    logic is_shift;
    logic take;

    assign take = op_valid && ready_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Shift and rotate datapath

    always_comb
    begin
        shift_res = opnd.dst_value;
        shift_c = status_flags_register[`BSE_FLAG_C];
        is_shift = 1'b1;
        case (op)
            bse_pkg::BSE_LOGICAL_LEFT_SHIFT:
            begin
                shift_res = {opnd.dst_value[6:0], 1'b0};
                shift_c = opnd.dst_value[7];
            end
            bse_pkg::BSE_LOGICAL_RIGHT_SHIFT:
            begin
                shift_res = {1'b0, opnd.dst_value[7:1]};
                shift_c = opnd.dst_value[0];
            end
            bse_pkg::BSE_ROTATE_LEFT_CARRY:
            begin
                shift_res = {opnd.dst_value[6:0], status_flags_register[`BSE_FLAG_C]};
                shift_c = opnd.dst_value[7];
            end
            bse_pkg::BSE_ROTATE_RIGHT_CARRY:
            begin
                shift_res = {status_flags_register[`BSE_FLAG_C], opnd.dst_value[7:1]};
                shift_c = opnd.dst_value[0];
            end
            bse_pkg::BSE_ARITH_RIGHT_SHIFT:
            begin
                shift_res = {opnd.dst_value[7], opnd.dst_value[7:1]};
                shift_c = opnd.dst_value[0];
            end
            default:
            begin
                is_shift = 1'b0;
            end
        endcase
        shift_n = shift_res[7];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state, results and flags

    always_comb
    begin
        state_next = state_reg;
        ready_next = ready_reg;
        dst_wr_next = '{wr_en: 1'b0, value: dst_wr_reg.value};
        io_wr_next = '{wr_en: 1'b0, addr: io_wr_reg.addr, data: io_wr_reg.data};
        io_hold_next = io_hold_reg;
        flags_next = status_flags_register;
        case (state_reg)
            bse_pkg::BSE_ST_IDLE:
            begin
                if (take)
                begin
                    if (is_shift)
                    begin
                        dst_wr_next = '{wr_en: 1'b1, value: shift_res};
                        flags_next[`BSE_FLAG_C] = shift_c;
                        flags_next[`BSE_FLAG_Z] = (shift_res == 8'h00);
                        flags_next[`BSE_FLAG_N] = shift_n;
                        flags_next[`BSE_FLAG_V] = shift_n ^ shift_c;
                    end
                    case (op)
                        bse_pkg::BSE_IO_BIT_SET:
                        begin
                            // Held one extra cycle so the write lands on the second edge
                            io_hold_next.wr_en = 1'b1;
                            io_hold_next.addr = opnd.io_addr;
                            io_hold_next.data = opnd.io_value | (8'h01 << opnd.bit_sel);
                            ready_next = 1'b0;
                            state_next = bse_pkg::BSE_ST_IO_HOLD;
                        end
                        bse_pkg::BSE_IO_BIT_CLEAR:
                        begin
                            io_wr_next.wr_en = 1'b1;
                            io_wr_next.addr = opnd.io_addr;
                            io_wr_next.data = opnd.io_value & ~(8'h01 << opnd.bit_sel);
                        end
                        bse_pkg::BSE_SWAP:
                        begin
                            dst_wr_next = '{wr_en: 1'b1, value: {opnd.dst_value[3:0], opnd.dst_value[7:4]}};
                        end
                        bse_pkg::BSE_FLAG_SET:
                        begin
                            flags_next[opnd.bit_sel] = 1'b1;
                        end
                        bse_pkg::BSE_FLAG_CLEAR:
                        begin
                            flags_next[opnd.bit_sel] = 1'b0;
                        end
                        bse_pkg::BSE_BIT_TO_T:
                        begin
                            flags_next[`BSE_FLAG_T] = opnd.source_register[opnd.bit_sel];
                        end
                        bse_pkg::BSE_T_TO_BIT:
                        begin
                            dst_wr_next.wr_en = 1'b1;
                            dst_wr_next.value = opnd.dst_value;
                            dst_wr_next.value[opnd.bit_sel] = status_flags_register[`BSE_FLAG_T];
                        end
                        bse_pkg::BSE_CARRY_SET:
                        begin
                            flags_next[`BSE_FLAG_C] = 1'b1;
                        end
                        bse_pkg::BSE_CARRY_CLEAR:
                        begin
                            flags_next[`BSE_FLAG_C] = 1'b0;
                        end
                        bse_pkg::BSE_NEG_SET:
                        begin
                            flags_next[`BSE_FLAG_N] = 1'b1;
                        end
                        bse_pkg::BSE_NEG_CLEAR:
                        begin
                            flags_next[`BSE_FLAG_N] = 1'b0;
                        end
                        default:
                        begin
                        end
                    endcase
                end
            end
            bse_pkg::BSE_ST_IO_HOLD:
            begin
                io_wr_next = io_hold_reg;
                io_hold_next.wr_en = 1'b0;
                ready_next = 1'b1;
                state_next = bse_pkg::BSE_ST_IDLE;
            end
            default:
            begin
                // Illegal code: fall back to idle rather than hang
                ready_next = 1'b1;
                state_next = bse_pkg::BSE_ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            state_reg <= bse_pkg::BSE_ST_IDLE;
            ready_reg <= 1'b1;
            dst_wr_reg <= '{wr_en: 1'b0, value: `BSE_DATA_RST};
            io_wr_reg <= '{wr_en: 1'b0, addr: `BSE_IOADDR_RST, data: `BSE_DATA_RST};
            io_hold_reg <= '{wr_en: 1'b0, addr: `BSE_IOADDR_RST, data: `BSE_DATA_RST};
            status_flags_register <= `BSE_FLAGS_RST;
        end
        else
        begin
            state_reg <= state_next;
            ready_reg <= ready_next;
            dst_wr_reg <= dst_wr_next;
            io_wr_reg <= io_wr_next;
            io_hold_reg <= io_hold_next;
            status_flags_register <= flags_next;
        end
    end

endmodule

`default_nettype wire

// File: test/bse_regfile_model.sv
`default_nettype none

// Far side: register file catching the write-backs
module bse_regfile_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire bse_pkg::bse_reg_wr_t dst_wr,
    input wire bse_pkg::bse_io_wr_t io_wr,
    output logic [7:0] wreg,
    output logic [7:0] ioreg
);
    timeunit 1ns;
    timeprecision 1ps;
    // No read port: the bench forwards operands itself, as the caller must
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || dst_wr.wr_en)
            wreg <= rst_n ? dst_wr.value : 8'h00;
        if (!rst_n || io_wr.wr_en)
            ioreg <= rst_n ? io_wr.data : 8'h00;
    end
endmodule

`default_nettype wire

// File: test/bse_unit_monitor.sv
`include "bse_regs.svh"
`default_nettype none

module bse_unit_monitor (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire bse_pkg::bse_op_t op,
    input wire bse_pkg::bse_operand_t opnd,
    input wire logic ready_reg,
    input wire bse_pkg::bse_reg_wr_t dst_wr_reg,
    input wire bse_pkg::bse_io_wr_t io_wr_reg,
    input wire logic [7:0] status_flags_register
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    logic tk;
    logic c;
    logic [7:0] d, f, v;
    assign tk = op_valid && ready_reg;
    assign d = opnd.dst_value;
    assign f = status_flags_register;
    assign v = dst_wr_reg.value;
    assign c = f[`BSE_FLAG_C];
    ////////////////////////////////////////////////////////////////
    a_io_set_late: assert property (
        tk && op == bse_pkg::BSE_IO_BIT_SET |=> !ready_reg && !io_wr_reg.wr_en ##1 io_wr_reg.wr_en
        && io_wr_reg.data == ($past(opnd.io_value, 2) | (8'h01 << $past(opnd.bit_sel, 2))))
        else $error("io set write wrong");
    a_left_shift_result: assert property (
        tk && op == bse_pkg::BSE_LOGICAL_LEFT_SHIFT |=> v == {$past(d[6:0]), 1'b0} && c == $past(d[7]))
        else $error("left shift wrong");
    a_right_shift_result: assert property (
        tk && op == bse_pkg::BSE_LOGICAL_RIGHT_SHIFT |=> v == {1'b0, $past(d[7:1])} && c == $past(d[0]))
        else $error("right shift wrong");
    a_rotate_left_result: assert property (
        tk && op == bse_pkg::BSE_ROTATE_LEFT_CARRY |=> v == {$past(d[6:0]), $past(c)} && c == $past(d[7]))
        else $error("rotate left wrong");
    a_rotate_right_result: assert property (
        tk && op == bse_pkg::BSE_ROTATE_RIGHT_CARRY |=> v == {$past(c), $past(d[7:1])} && c == $past(d[0]))
        else $error("rotate right wrong");
    a_arith_shift_result: assert property (
        tk && op == bse_pkg::BSE_ARITH_RIGHT_SHIFT |=> v == {$past(d[7]), $past(d[7:1])} && c == $past(d[0]))
        else $error("arithmetic shift wrong");
    a_swap_halves: assert property (
        tk && op == bse_pkg::BSE_SWAP |=> dst_wr_reg.wr_en && v == {$past(d[3:0]), $past(d[7:4])} && $stable(f))
        else $error("swap wrong");
    a_shift_flags: assert property (
        tk && op inside {[bse_pkg::BSE_LOGICAL_LEFT_SHIFT:bse_pkg::BSE_ARITH_RIGHT_SHIFT]}
        |=> f[`BSE_FLAG_Z] == (v == 8'h00)
        && f[`BSE_FLAG_N] == v[7] && f[`BSE_FLAG_V] == (v[7] ^ c))
        else $error("shift flags wrong");
    cover property (tk && op == bse_pkg::BSE_IO_BIT_SET);
    cover property (op_valid && !ready_reg);
    cover property (tk && op == bse_pkg::BSE_ROTATE_LEFT_CARRY && c);
endmodule

bind bse_unit bse_unit_monitor mon (.sys_clk, .rst_n, .op_valid, .op, .opnd, .ready_reg, .dst_wr_reg,
    .io_wr_reg, .status_flags_register);

`default_nettype wire

// File: test/bse_unit_tb_top.sv
`include "bse_regs.svh"
`default_nettype none

module bse_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic op_valid = 1'b0;
    bse_pkg::bse_op_t op = bse_pkg::BSE_SWAP;
    bse_pkg::bse_operand_t opnd = '0;
    logic ready_reg;
    bse_pkg::bse_reg_wr_t dst_wr_reg;
    bse_pkg::bse_io_wr_t io_wr_reg;
    logic [7:0] status_flags_register, wreg, ioreg, fl;
    logic [8:0] e;
    logic [7:0] vals [3] = '{8'h81, 8'h80, 8'h01};
    int error_cnt = 0;
    int n_compared = 0;
    always #2.5 sys_clk = ~sys_clk;
    bse_unit dut (.sys_clk, .rst_n, .op_valid, .op, .opnd, .ready_reg, .dst_wr_reg, .io_wr_reg,
        .status_flags_register);
    bse_regfile_model rf (.sys_clk, .rst_n, .dst_wr(dst_wr_reg), .io_wr(io_wr_reg), .wreg, .ioreg);
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One op, with a gap after it; returns once the results have landed
    task automatic issue(input bse_pkg::bse_op_t o, input logic [7:0] dv, input logic [7:0] s, input logic [2:0] b);
        @(posedge sys_clk);
        op_valid <= 1'b1;
        op <= o;
        opnd <= {dv, s, dv, 6'h2A, b};
        @(posedge sys_clk);
        op_valid <= 1'b0;
        #1;
    endtask
    function automatic logic [8:0] shf(input bse_pkg::bse_op_t o, input logic [7:0] dv, input logic ci);
        case (o)
            bse_pkg::BSE_LOGICAL_LEFT_SHIFT: return {dv, 1'b0};
            bse_pkg::BSE_LOGICAL_RIGHT_SHIFT: return {dv[0], 1'b0, dv[7:1]};
            bse_pkg::BSE_ROTATE_LEFT_CARRY: return {dv, ci};
            bse_pkg::BSE_ROTATE_RIGHT_CARRY: return {dv[0], ci, dv[7:1]};
            default: return {dv[0], dv[7], dv[7:1]};
        endcase
    endfunction
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        fl = `BSE_FLAGS_RST;
        #1;
        check(status_flags_register, fl);
        for (int i = 0; i < 16; i++)
        begin
            issue(i < 8 ? bse_pkg::BSE_FLAG_SET : bse_pkg::BSE_FLAG_CLEAR, 8'h00, 8'h00, i[2:0]);
            fl[i[2:0]] = (i < 8);
            check(status_flags_register, fl);
            check(dst_wr_reg.wr_en, 1'b0);
        end
        for (int k = 12; k < 16; k++)
        begin
            issue(bse_pkg::bse_op_t'(k[3:0]), 8'h00, 8'h00, 3'h0);
            fl[k < 14 ? `BSE_FLAG_C : `BSE_FLAG_N] = !k[0];
            check(status_flags_register, fl);
        end
        $display("flag ops done");
        for (int o = 2; o < 7; o++)
            foreach (vals[j])
            begin
                issue(bse_pkg::bse_op_t'(o[3:0]), vals[j], 8'h00, 3'h0);
                e = shf(bse_pkg::bse_op_t'(o[3:0]), vals[j], fl[`BSE_FLAG_C]);
                fl[`BSE_FLAG_C] = e[8];
                fl[`BSE_FLAG_Z] = (e[7:0] == 8'h00);
                fl[`BSE_FLAG_N] = e[7];
                fl[`BSE_FLAG_V] = e[7] ^ e[8];
                check(dst_wr_reg.value, e[7:0]);
                check(dst_wr_reg.wr_en, 1'b1);
                check(status_flags_register, fl);
            end
        $display("shifts done");
        issue(bse_pkg::BSE_SWAP, 8'hA5, 8'h00, 3'h0);
        check(dst_wr_reg.value, 8'h5A);
        check(dst_wr_reg.wr_en, 1'b1);
        check(status_flags_register, fl);
        issue(bse_pkg::BSE_BIT_TO_T, 8'h00, 8'h08, 3'h3);
        fl[`BSE_FLAG_T] = 1'b1;
        check(status_flags_register, fl);
        check(dst_wr_reg.wr_en, 1'b0);
        issue(bse_pkg::BSE_T_TO_BIT, 8'h81, 8'h00, 3'h5);
        check(dst_wr_reg.value, 8'hA1);
        check(dst_wr_reg.wr_en, 1'b1);
        check(status_flags_register, fl);
        @(posedge sys_clk);
        #1;
        check(wreg, 8'hA1);
        $display("bit moves done");
        issue(bse_pkg::BSE_IO_BIT_CLEAR, 8'hFF, 8'h00, 3'h0);
        check(io_wr_reg.data, 8'hFE);
        check(io_wr_reg.wr_en, 1'b1);
        check({2'b00, io_wr_reg.addr}, 8'h2A);
        check(status_flags_register, fl);
        // Flag set held while busy must be dropped, so the I flag stays low
        @(posedge sys_clk);
        op_valid <= 1'b1;
        op <= bse_pkg::BSE_IO_BIT_SET;
        opnd <= {8'h00, 8'h00, 8'h10, 6'h2A, 3'h7};
        @(posedge sys_clk);
        op <= bse_pkg::BSE_FLAG_SET;
        #1;
        check(ready_reg, 1'b0);
        check(io_wr_reg.wr_en, 1'b0);
        @(posedge sys_clk);
        op_valid <= 1'b0;
        #1;
        check(io_wr_reg.data, 8'h90);
        check(io_wr_reg.wr_en, 1'b1);
        check(ready_reg, 1'b1);
        check(status_flags_register, fl);
        @(posedge sys_clk);
        #1;
        check(ioreg, 8'h90);
        $display("io ops done");
        // Reset while an I/O set is pending must drop the held write
        @(posedge sys_clk);
        op_valid <= 1'b1;
        op <= bse_pkg::BSE_IO_BIT_SET;
        @(posedge sys_clk);
        op_valid <= 1'b0;
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        check(ready_reg, 1'b1);
        check(io_wr_reg.wr_en, 1'b0);
        fl = `BSE_FLAGS_RST;
        check(status_flags_register, fl);
        issue(bse_pkg::BSE_LOGICAL_LEFT_SHIFT, 8'h40, 8'h00, 3'h0);
        fl[`BSE_FLAG_N] = 1'b1;
        fl[`BSE_FLAG_V] = 1'b1;
        check(dst_wr_reg.value, 8'h80);
        check(status_flags_register, fl);
        $display("mid-run reset done");
        close_out();
    end
    // Run needs well under 1000 cycles; five microseconds only trips on a hang
    initial
    begin
        #5000;
        error_cnt++;
        close_out();
    end
endmodule

`default_nettype wire
